// ---- logic/hbt_target.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hbt_consts.svh"
// Behaviour
// - Every nibble on the bus is sampled on the rising clock edge.
// - Standby when framing high, idle and array not busy; ready when framing low and idle.
// - Framing low with start code 1101 begins a read.
// - Framing low with start code 1110 begins a write.
// - Only the last start nibble before framing rises sets cycle type.
// - Clock 2 nibble must match strapped identity to continue.
// - Clocks 3 to 9 carry a 28-bit address, high nibble first.
// - Only the low 20 address bits are decoded.
// - Address bit 22 selects flash array when one, registers when zero.
// - Clock 10 size nibble; only 0000, one byte, is supported.
// - Read: device takes bus in clock 12, ready-sync 0000 in 13.
// - Read: low data nibble in clock 14, high in clock 15.
// - Read: device drives 1111 in clock 16, then floats.
// - Write: device takes bus in clock 14, drives 0000 in 15.
// - Write: device drives 1111 in clock 16, then floats.
// - Framing low mid-cycle ends the cycle; wait for abort code.
// - Abort code 1111 returns device to ready state.
// - No explicit signal of invalid fields or sequences.
// - Program and erase ride on writes; whole-chip erase refused.
// - Size other than 0000 resets the logic with no response.
// - Identity mismatch ignores rest of cycle, enters standby.
// - Protocol active only while interface select pin is low.
// - Reset deselects the device and floats the nibble drivers.
module hbt_target (
   input wire logic clk, // bus clock
   input wire logic rst_b, // async reset, active low
   input wire logic frame_start_n, // framing, active low
   input wire logic [3:0] nibble_bus_in, // nibble bus level
   output logic [3:0] nibble_bus_out, // nibble bus drive value
   output logic nibble_bus_oe, // nibble bus drive enable
   input wire logic [3:0] strap_identity_pins, // strapped identity
   input wire logic interface_select_pin, // high disables this bus
   input wire logic array_busy, // internal operation running
   input wire logic [7:0] rd_data, // read byte from array or registers
   output logic [19:0] mem_addr, // decoded low address bits
   output logic space_flash, // one: flash array, zero: registers
   output logic [7:0] wr_data, // written byte or command
   output logic rd_req, // read request pulse
   output logic wr_req, // write request pulse
   output logic standby, // standby state
   output logic ready // ready state
);
   import hbt_pkg::*;

   hbt_core_t q;
   hbt_core_t n;
   logic [4:0] pins_sync;
   logic [3:0] ident;
   logic isel;
   logic drive_d;
   logic [3:0] nib_d;
   logic [7:0] wbyte;
   logic is_start;
   logic in_cycle;

   // ==================================================
   // static straps cross in through the pin synchroniser
   hbt_pin_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pins({interface_select_pin, strap_identity_pins}),
      .value(pins_sync)
   );

   // select pin rides on top of the identity straps
   assign ident = pins_sync[3:0];
   assign isel = pins_sync[4];

   // start codes; host and device share the clock, so no sync
   assign is_start = (nibble_bus_in == `HBT_START_READ) || (nibble_bus_in == `HBT_START_WRITE);
   // abort watch skips idle, start, abort and the hand-back clock
   assign in_cycle = (q.st != HBT_IDLE) && (q.st != HBT_START) && (q.st != HBT_ABORT) && (q.st != HBT_TURN_BACK);
   assign wbyte = {nibble_bus_in, q.wlow};

   // ==================================================
   // cycle decoder, one field per clock
   always_comb begin
      n = q;
      n.rd_req = 1'b0;
      n.wr_req = 1'b0;
      case (q.st)
         HBT_IDLE, HBT_TURN_BACK: begin
            n.st = HBT_IDLE;
            if (!frame_start_n && is_start) begin
               n.st = HBT_START;
               n.is_wr = (nibble_bus_in == `HBT_START_WRITE);
            end
         end
         HBT_START: begin
            // a non-start nibble under framing cancels the open start
            if (!frame_start_n) begin
               if (is_start) begin
                  n.is_wr = (nibble_bus_in == `HBT_START_WRITE); // latest start wins
               end else begin
                  n.st = HBT_IDLE;
               end
            end else if (nibble_bus_in == ident) begin
               n.st = HBT_ADDR;
               n.cnt = 3'h0;
            end else begin
               n.st = HBT_IDLE; // not ours, drop to standby
            end
         end
         HBT_ADDR: begin
            n.addr = {q.addr[23:0], nibble_bus_in}; // high nibble first
            if (q.cnt == `HBT_ADDR_LAST_CNT) begin
               n.st = HBT_SIZE;
            end else begin
               n.cnt = q.cnt + 3'h1;
            end
         end
         HBT_SIZE: begin
            if (nibble_bus_in != `HBT_SIZE_ONE_BYTE) begin
               n.st = HBT_IDLE; // silent reset, no request
            end else if (q.is_wr) begin
               n.st = HBT_WDATA_LO;
            end else begin
               n.st = HBT_TURN_HOST;
               n.rd_req = 1'b1;
            end
         end
         HBT_WDATA_LO: begin
            n.wlow = nibble_bus_in;
            n.st = HBT_WDATA_HI;
         end
         HBT_WDATA_HI: begin
            n.st = HBT_TURN_HOST;
            n.wdata = wbyte;
            // chip erase confirm after erase setup is swallowed, still acknowledged
            n.wr_req = !(q.guard && (wbyte == `HBT_CMD_CHIP_CONFIRM));
            if (wbyte == `HBT_CMD_ERASE_SETUP) begin
               n.guard = 1'b1;
            end else if ((wbyte != `HBT_CMD_UNLOCK_A) && (wbyte != `HBT_CMD_UNLOCK_B)) begin
               n.guard = 1'b0;
            end
         end
         HBT_TURN_HOST: begin
            n.st = HBT_TURN_DEV; // host drives ones, device stays off
         end
         HBT_TURN_DEV: begin
            n.st = HBT_SYNC;
            if (!q.is_wr) begin
               n.rdata = rd_data; // array has had two clocks to answer
            end
         end
         HBT_SYNC: begin
            n.st = q.is_wr ? HBT_TURN_OUT : HBT_RDATA_LO;
         end
         HBT_RDATA_LO: begin
            n.st = HBT_RDATA_HI;
         end
         HBT_RDATA_HI: begin
            n.st = HBT_TURN_OUT;
         end
         HBT_TURN_OUT: begin
            n.st = HBT_TURN_BACK;
         end
         HBT_ABORT: begin
            // start codes are ignored here; only the abort code leaves
            if (!frame_start_n && (nibble_bus_in == `HBT_ABORT_CODE)) begin
               n.st = HBT_IDLE;
            end
         end
         default: begin
            n.st = HBT_IDLE;
         end
      endcase
      // framing low inside a cycle kills it; a half write may be lost
      if (in_cycle && !frame_start_n) begin
         n.st = HBT_ABORT;
         n.rd_req = 1'b0;
         n.wr_req = 1'b0;
      end
      // select pin high hands the pins to the other mode
      if (isel) begin
         n.st = HBT_IDLE;
         n.rd_req = 1'b0;
         n.wr_req = 1'b0;
      end
   end

   // ==================================================
   // driver plan for the next clock, from the next state
   always_comb begin
      drive_d = 1'b1;
      nib_d = `HBT_TURN_ONES;
      case (n.st)
         HBT_SYNC: nib_d = `HBT_READY_SYNC;
         HBT_RDATA_LO: nib_d = n.rdata[3:0];
         HBT_RDATA_HI: nib_d = n.rdata[7:4];
         HBT_TURN_OUT: nib_d = `HBT_TURN_ONES;
         default: drive_d = 1'b0;
      endcase
   end

   // registered pin driver; a float is simply oe low
   hbt_nibble_drv u_drv (
      .clk(clk),
      .rst_b(rst_b),
      .drive_d(drive_d),
      .nib_d(nib_d),
      .bus_oe(nibble_bus_oe),
      .bus_out(nibble_bus_out)
   );

   // ==================================================
   // decoder state register; reset drops a running cycle at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= {HBT_IDLE, 1'b0, 3'h0, `HBT_RST_ADDR, `HBT_RST_NIBBLE, `HBT_RST_BYTE, `HBT_RST_BYTE, 1'b0, 1'b0, 1'b0};
      end else begin
         q <= n;
      end
   end

   // ==================================================
   // inward handoff and status
   assign mem_addr = q.addr[`HBT_DECODE_BITS-1:0]; // upper nibbles ignored
   assign space_flash = q.addr[`HBT_SPACE_BIT];
   assign wr_data = q.wdata;
   assign rd_req = q.rd_req;
   assign wr_req = q.wr_req;
   assign standby = frame_start_n && (q.st == HBT_IDLE) && !array_busy;
   assign ready = !frame_start_n && (q.st == HBT_IDLE);

   // ==================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // run: framing high and this bus mode selected, so no abort can start
   logic run;
   assign run = frame_start_n && !isel;

   sequence s_read_head;
      rd_req && run ##1 run ##1 run ##1 run ##1 run;
   endsequence

   sequence s_write_head;
      (q.st == HBT_TURN_HOST) && q.is_wr && run ##1 run ##1 run;
   endsequence

   sequence s_write_tail;
      (nibble_bus_oe && nibble_bus_out == 4'h0) ##1 (nibble_bus_oe && nibble_bus_out == 4'hF) ##1 !nibble_bus_oe;
   endsequence

   // read answer: sync, two data nibbles, ones, then release
   a_read_sync: assert property (rd_req && run ##1 run |=> nibble_bus_oe && nibble_bus_out == 4'h0)
      else $error("read ready-sync not driven in its clock");
   a_read_tail: assert property (s_read_head |=> (nibble_bus_oe && nibble_bus_out == 4'hF) ##1 !nibble_bus_oe)
      else $error("read turnaround ones or release wrong");
   a_read_data: assert property ((q.st == HBT_RDATA_LO) |-> nibble_bus_out == $past(rd_data[3:0], 2))
      else $error("read low nibble does not match array byte");
   a_read_high: assert property ((q.st == HBT_RDATA_HI) |-> nibble_bus_out == $past(rd_data[7:4], 3))
      else $error("read high nibble does not match array byte");

   // write answer, and the quiet turnaround clocks of both kinds
   a_write_ack: assert property (s_write_head |-> s_write_tail)
      else $error("write acknowledge sequence wrong");
   a_turn_quiet: assert property ((q.st == HBT_TURN_DEV) || (q.st == HBT_TURN_HOST) |-> !nibble_bus_oe)
      else $error("nibble bus driven in a turnaround clock");
   a_write_byte: assert property ((q.st == HBT_TURN_HOST) && q.is_wr |-> wr_data == {$past(nibble_bus_in, 1),
      $past(nibble_bus_in, 2)})
      else $error("written byte differs from the data nibbles");
   a_drive_window: assert property (nibble_bus_oe |->
      (q.st inside {HBT_SYNC, HBT_RDATA_LO, HBT_RDATA_HI, HBT_TURN_OUT}))
      else $error("nibble bus driven outside device clocks");

   // refusals: abort, foreign identity, bad size, erase guard, select pin
   a_abort_entry: assert property (in_cycle && !frame_start_n && !isel |=>
      q.st == HBT_ABORT && !nibble_bus_oe)
      else $error("mid-cycle framing did not abort");
   a_abort_ready: assert property ((q.st == HBT_ABORT) && !frame_start_n && nibble_bus_in == 4'hF && !isel |=>
      q.st == HBT_IDLE && ready == !frame_start_n)
      else $error("abort code did not return to ready");
   a_id_mismatch: assert property ((q.st == HBT_START) && frame_start_n && nibble_bus_in != ident |=>
      q.st == HBT_IDLE ##1 !nibble_bus_oe)
      else $error("identity mismatch not ignored");
   a_size_bad: assert property ((q.st == HBT_SIZE) && frame_start_n && nibble_bus_in != 4'h0 |=>
      !rd_req && !wr_req && q.st == HBT_IDLE)
      else $error("bad size field still answered");
   a_last_start: assert property ((q.st == HBT_START) && !frame_start_n && nibble_bus_in == 4'hE |=> q.is_wr)
      else $error("later start code not taken");
   a_chip_erase: assert property ((q.st == HBT_WDATA_HI) && q.guard && wbyte == 8'h10 && run |=> !wr_req)
      else $error("chip erase confirm passed inward");
   a_isel_off: assert property (isel |=> !nibble_bus_oe && !rd_req && !wr_req)
      else $error("bus active while interface select high");

   // inward handoff: single-clock requests, address from the last five nibbles
   a_rd_pulse: assert property (rd_req |=> !rd_req)
      else $error("read request longer than one clock");
   a_wr_pulse: assert property (wr_req |=> !wr_req)
      else $error("write request longer than one clock");
   a_addr_hand: assert property (rd_req |-> mem_addr == {$past(nibble_bus_in, 6), $past(nibble_bus_in, 5),
      $past(nibble_bus_in, 4), $past(nibble_bus_in, 3), $past(nibble_bus_in, 2)})
      else $error("decoded address differs from the bus nibbles");
endmodule
`default_nettype wire

// ---- logic/hbt_consts.svh ----
`ifndef HBT_CONSTS_SVH
`define HBT_CONSTS_SVH

// ==================================================
// field codes on the nibble bus
`define HBT_START_READ 4'hD
`define HBT_START_WRITE 4'hE
`define HBT_ABORT_CODE 4'hF
`define HBT_SIZE_ONE_BYTE 4'h0
`define HBT_READY_SYNC 4'h0
`define HBT_TURN_ONES 4'hF

// ==================================================
// address layout
`define HBT_ADDR_NIBBLES 3'h7
`define HBT_ADDR_LAST_CNT 3'h6
`define HBT_ADDR_BITS 28
`define HBT_DECODE_BITS 20
`define HBT_SPACE_BIT 22

// ==================================================
// command bytes watched for the whole-chip erase guard
`define HBT_CMD_UNLOCK_A 8'hAA
`define HBT_CMD_UNLOCK_B 8'h55
`define HBT_CMD_ERASE_SETUP 8'h80
`define HBT_CMD_CHIP_CONFIRM 8'h10

// ==================================================
// reset values
`define HBT_RST_NIBBLE 4'h0
`define HBT_RST_BYTE 8'h00
`define HBT_RST_ADDR 28'h0000000
`define HBT_RST_SYNC 5'h00

`endif

// ---- logic/hbt_pkg.sv ----
`default_nettype none
package hbt_pkg;

   // ==================================================
   // bus cycle states, named after the clock being sampled
   typedef enum logic [3:0] {
      HBT_IDLE = 4'b0000,
      HBT_START = 4'b0001,
      HBT_ADDR = 4'b0010,
      HBT_SIZE = 4'b0011,
      HBT_WDATA_LO = 4'b0100,
      HBT_WDATA_HI = 4'b0101,
      HBT_TURN_HOST = 4'b0110,
      HBT_TURN_DEV = 4'b0111,
      HBT_SYNC = 4'b1000,
      HBT_RDATA_LO = 4'b1001,
      HBT_RDATA_HI = 4'b1010,
      HBT_TURN_OUT = 4'b1011,
      HBT_TURN_BACK = 4'b1100,
      HBT_ABORT = 4'b1101
   } hbt_state_t;

   // ==================================================
   // state of the cycle decoder
   typedef struct packed {
      hbt_state_t st;
      logic is_wr;
      logic [2:0] cnt;
      logic [27:0] addr;
      logic [3:0] wlow;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic guard;
      logic rd_req;
      logic wr_req;
   } hbt_core_t;

   // ==================================================
   // state of the static pin synchroniser
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] val;
   } hbt_sync_t;

   // ==================================================
   // state of the nibble bus driver
   typedef struct packed {
      logic oe;
      logic [3:0] nib;
   } hbt_drv_t;

endpackage
`default_nettype wire

// ---- logic/hbt_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hbt_consts.svh"
module hbt_pin_sync (
   input wire logic clk, // bus clock
   input wire logic rst_b, // async reset, active low
   input wire logic [4:0] pins, // static straps from outside
   output logic [4:0] value // agreed level
);
   import hbt_pkg::*;

   hbt_sync_t q;
   hbt_sync_t d;

   // ==================================================
   // three stages; only the last two are compared
   always_comb begin
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.val = q.s3; // a change counts once both agree
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= {`HBT_RST_SYNC, `HBT_RST_SYNC, `HBT_RST_SYNC, `HBT_RST_SYNC};
      end else begin
         q <= d;
      end
   end

   assign value = q.val;
endmodule
`default_nettype wire

// ---- logic/hbt_nibble_drv.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hbt_consts.svh"
module hbt_nibble_drv (
   input wire logic clk, // bus clock
   input wire logic rst_b, // async reset, active low
   input wire logic drive_d, // drive in the next clock
   input wire logic [3:0] nib_d, // nibble for the next clock
   output logic bus_oe, // pin driver enable
   output logic [3:0] bus_out // pin driver value
);
   import hbt_pkg::*;

   hbt_drv_t q;
   hbt_drv_t d;

   // ==================================================
   // registered so the pins never glitch mid clock
   always_comb begin
      d.oe = drive_d;
      d.nib = drive_d ? nib_d : `HBT_RST_NIBBLE;
   end

   // reset drops the driver at once, even inside a read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= {1'b0, `HBT_RST_NIBBLE};
      end else begin
         q <= d;
      end
   end

   assign bus_oe = q.oe;
   assign bus_out = q.nib;
endmodule
`default_nettype wire

// ---- bench/hbt_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbt_host_model (
   input wire logic clk, // bus clock
   input wire logic dev_oe, // device drive enable
   input wire logic [3:0] dev_nib, // device drive value
   output logic frame_n, // framing to the device
   output logic [3:0] level // resolved bus level
);
   logic h_oe;
   logic [3:0] h_nib;
   logic [3:0] flt_q;
   int k;
   logic seen_oe [0:17];
   logic [3:0] seen_nib [0:17];

   // ==================================================
   // wire resolution
   initial begin
      frame_n = 1'b1;
      h_oe = 1'b0;
      h_nib = 4'h0;
      flt_q = 4'h5;
      k = 0;
   end
   // a released bus wanders every clock, so a stale nibble never passes as data
   always @(posedge clk) flt_q <= ~flt_q;
   assign level = h_oe ? h_nib : (dev_oe ? dev_nib : flt_q);

   // ==================================================
   // one memory cycle, clock by clock; ab is the first abort clock
   task automatic cycle(input logic wr, input logic [3:0] id, input logic [27:0] a, input logic [3:0] sz,
                        input logic [7:0] wd, input logic [3:0] pre, input int ab);
      for (int i = (pre != 4'h0) ? 0 : 1; i <= 17; i++) begin
         @(posedge clk);
         #5;
         k = i;
         frame_n = (i <= 1 || (i >= ab && i < ab + 2)) ? 1'b0 : 1'b1;
         h_oe = (i <= 11) || (wr && i <= 13);
         case (i)
            0: h_nib = pre;
            1: h_nib = wr ? 4'hE : 4'hD;
            2: h_nib = id;
            10: h_nib = sz;
            11: h_nib = wr ? wd[3:0] : 4'hF;
            12: h_nib = wd[7:4];
            13: h_nib = 4'hF;
            default: h_nib = (i >= 3 && i <= 9) ? a[4 * (9 - i) +: 4] : 4'hF;
         endcase
         if (i >= ab + 2) h_oe = 1'b0;
         if (i >= ab && i < ab + 2) begin
            h_oe = 1'b1;
            h_nib = 4'hF;
         end
         seen_oe[i] = dev_oe;
         seen_nib[i] = dev_nib;
      end
   endtask

   // idle clock with chosen framing and nibble
   task automatic idle(input logic f, input logic [3:0] n);
      @(posedge clk);
      #5;
      frame_n = f;
      h_oe = 1'b1;
      h_nib = n;
      k = 0;
   endtask
endmodule
`default_nettype wire

// ---- bench/hbt_target_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbt_target_tb;
   typedef struct packed {
      logic wr;
      logic [3:0] id;
      logic [27:0] a;
      logic [3:0] sz;
      logic [7:0] d;
      logic [3:0] pre;
      logic req;
   } hbt_row_t;
   logic clk, rst_b, frame_start_n, nibble_bus_oe, isel, array_busy, space_flash, rd_req, wr_req, standby, ready;
   logic [3:0] nibble_bus_in, nibble_bus_out, strap;
   logic [7:0] rd_data, wr_data;
   logic [19:0] mem_addr;
   logic rq [0:17];
   logic wq [0:17];
   hbt_row_t rows [0:14];
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;

   hbt_target uut (.clk(clk), .rst_b(rst_b), .frame_start_n(frame_start_n), .nibble_bus_in(nibble_bus_in),
      .nibble_bus_out(nibble_bus_out), .nibble_bus_oe(nibble_bus_oe), .strap_identity_pins(strap),
      .interface_select_pin(isel), .array_busy(array_busy), .rd_data(rd_data), .mem_addr(mem_addr),
      .space_flash(space_flash), .wr_data(wr_data), .rd_req(rd_req), .wr_req(wr_req), .standby(standby),
      .ready(ready));
   hbt_host_model host (.clk(clk), .dev_oe(nibble_bus_oe), .dev_nib(nibble_bus_out), .frame_n(frame_start_n),
      .level(nibble_bus_in));

   // ==================================================
   // clock, timeout and request capture
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // whole run is well under this many clocks
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         wrap_up();
      end
   end
   // requests are pulses, so file them under the current bus clock number
   always @(posedge clk) begin
      #6;
      rq[host.k] = rd_req;
      wq[host.k] = wr_req;
   end

   // ==================================================
   // helpers
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one row: run the cycle, then judge clocks 1 to 17 of it
   task automatic run_row(input hbt_row_t r, input logic on);
      logic resp, eo;
      logic [3:0] en;
      resp = on && (r.id === 4'h9) && (r.sz === 4'h0);
      rd_data = r.d;
      host.cycle(r.wr, r.id, r.a, r.sz, r.d, r.pre, 99);
      for (int i = 1; i <= 17; i++) begin
         eo = resp && (r.wr ? (i == 15 || i == 16) : (i >= 13 && i <= 16));
         en = (i == 16) ? 4'hF : (r.wr || i == 13) ? 4'h0 : (i == 14) ? r.d[3:0] : r.d[7:4];
         check("drive_en", host.seen_oe[i], eo);
         if (eo) check("drive_val", host.seen_nib[i], en);
         if (i <= 16) check("rd_req", rq[i], resp && !r.wr && i == 11);
         if (i <= 16) check("wr_req", wq[i], resp && r.wr && r.req && i == 13);
      end
      if (resp) begin
         check("mem_addr", mem_addr, r.a[19:0]);
         check("space", space_flash, r.a[22]);
         if (r.wr) check("wr_data", wr_data, r.d);
      end
      $display("test row done addr %h", r.a);
   endtask

   // ==================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      isel = 1'b0;
      array_busy = 1'b0;
      strap = 4'h9;
      rd_data = 8'h00;
      rows = '{'{0, 4'h9, 28'hFF7A5C3, 4'h0, 8'hA5, 4'h0, 1}, '{0, 4'h9, 28'h0B12345, 4'h0, 8'h3C, 4'h0, 1},
         '{1, 4'h9, 28'h8D0F00E, 4'h0, 8'h5A, 4'h0, 1}, '{1, 4'h9, 28'h0012345, 4'h0, 8'hC3, 4'h0, 1},
         '{0, 4'h3, 28'h0F00001, 4'h0, 8'h11, 4'h0, 0}, '{0, 4'h9, 28'h0F00002, 4'h1, 8'h22, 4'h0, 0},
         '{1, 4'h9, 28'h0F00003, 4'hF, 8'h33, 4'h0, 0}, '{0, 4'h9, 28'h0F00004, 4'h0, 8'h96, 4'hE, 1},
         '{1, 4'h9, 28'h0F00005, 4'h0, 8'h69, 4'hD, 1}, '{1, 4'h9, 28'h0F05555, 4'h0, 8'hAA, 4'h0, 1},
         '{1, 4'h9, 28'h0F02AAA, 4'h0, 8'h55, 4'h0, 1}, '{1, 4'h9, 28'h0F05555, 4'h0, 8'h80, 4'h0, 1},
         '{1, 4'h9, 28'h0F05555, 4'h0, 8'hAA, 4'h0, 1}, '{1, 4'h9, 28'h0F02AAA, 4'h0, 8'h55, 4'h0, 1},
         '{1, 4'h9, 28'h0F05555, 4'h0, 8'h10, 4'h0, 0}};
      repeat (6) @(posedge clk);
      #5;
      check("oe_in_reset", nibble_bus_oe, 1'b0);
      rst_b = 1'b1;
      repeat (8) @(posedge clk);
      #5;
      check("standby_idle", standby, 1'b1);
      check("ready_idle", ready, 1'b0);
      foreach (rows[n]) run_row(rows[n], 1'b1);
      // status levels
      host.idle(1'b1, 4'h0);
      array_busy = 1'b1;
      #1 check("standby_busy", standby, 1'b0);
      host.idle(1'b0, 4'h0);
      array_busy = 1'b0;
      #1 check("ready_low", ready, 1'b1);
      check("standby_low", standby, 1'b0);
      host.idle(1'b1, 4'h0);
      $display("test status done");
      // abort in mid write, then a normal read must work
      host.cycle(1'b1, 4'h9, 28'h0F00006, 4'h0, 8'hEE, 4'h0, 8);
      for (int i = 1; i <= 16; i++) begin
         check("abort_oe", host.seen_oe[i], 1'b0);
         check("abort_wr", wq[i], 1'b0);
      end
      run_row(rows[0], 1'b1);
      // bus logic off while the select pin is high
      isel = 1'b1;
      repeat (6) @(posedge clk);
      run_row(rows[1], 1'b0);
      isel = 1'b0;
      repeat (6) @(posedge clk);
      // reset while the device drives read data
      fork
         host.cycle(1'b0, 4'h9, 28'h0F00007, 4'h0, 8'h77, 4'h0, 99);
         begin
            wait (host.k == 14);
            #1 check("oe_before_rst", nibble_bus_oe, 1'b1);
            rst_b = 1'b0;
            #1 check("oe_after_rst", nibble_bus_oe, 1'b0);
         end
      join
      rst_b = 1'b1;
      repeat (8) @(posedge clk);
      run_row(rows[1], 1'b1);
      $display("test hand cases done");
      wrap_up();
   end
endmodule
`default_nettype wire
